// ### rtl/uep_profiling_regs.sv
// Configuration and control-block address registers of user event profiling
`timescale 1ns/10ps

// Functional notes
// - Registers accessible only when profiling reported
// - Setting unsupported feature bit faults
// - Bits 31:1 mirrored to unprivileged identification
// - Core identifier copied into every record
// - Bits 47:40 give threshold interrupt vector
// - Bits 1..6 permit individual events
// - Bit 29 continuous mode, else synchronized
// - Bit 30 stores timestamp when counter exists
// - Bit 31 permits threshold interrupt
// - Address read returns value without flushing
// - Non-zero address write faults
// - Zero address write stops, discards state
// - Control block kept as linear address
// - Instructions fault when unsupported or disabled
// - Load enables and selects, store reports
// - Insert records whenever enabled, sample on underflow
module uep_profiling_regs (
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_n_in,
	input  wire logic [31:0]                   ext_feature_id_in,
	input  wire logic [31:0]                   feature_support_in,
	input  wire logic [63:0]                   extended_state_enable_mask_in,
	input  wire logic                          timestamp_present_in,
	input  wire logic                          msr_rd_in,
	input  wire logic                          msr_wr_in,
	input  wire logic [31:0]                   msr_addr_in,
	input  wire logic [63:0]                   msr_wdata_in,
	input  wire logic                          instr_valid_in,
	input  wire logic [1:0]                    instr_op_in,
	input  wire logic [63:0]                   instr_addr_in,
	input  wire logic [5:0]                    instr_flags_in,
	input  wire logic [uep_pkg::UEP_CNT_W-1:0] instr_count_in,
	input  wire logic [uep_pkg::UEP_CNT_W-1:0] instr_interval_in,
	input  wire logic                          restore_valid_in,
	input  wire logic [63:0]                   restore_addr_in,
	output logic                               msr_ack_out,
	output logic                               msr_gp_fault_out,
	output logic [63:0]                        msr_rdata_out,
	output logic                               instr_done_out,
	output logic                               instr_ud_fault_out,
	output logic [63:0]                        instr_result_out,
	output logic                               record_valid_out,
	output logic [7:0]                         record_event_id_out,
	output logic [7:0]                         record_core_id_out,
	output logic                               record_timestamp_out,
	output logic [31:0]                        id_leaf_out,
	output logic [5:0]                         event_permit_out,
	output logic                               continuous_mode_out,
	output logic                               timestamp_store_enable_out,
	output logic                               threshold_int_permit_out,
	output logic [7:0]                         int_vector_out,
	output logic [7:0]                         core_identifier_out,
	output logic                               profiling_enabled_out
);

	typedef struct packed {
		logic [63:0]        cfg;
		logic [63:0]        cbaddr;
		uep_pkg::uep_mode_e mode;
		logic [5:0]         evt_sel;
		logic               ack;
		logic               gp;
		logic [63:0]        rdata;
		logic               done;
		logic               ud;
		logic [63:0]        result;
		logic               rec_valid;
		logic [7:0]         rec_id;
		logic [7:0]         rec_core;
		logic               rec_ts;
	} uep_state_s;

	uep_state_s        st_reg;
	uep_state_s        st_next;
	logic              prof_sup;
	logic              prof_avail;
	logic [63:0]       cfg_allowed;
	uep_pkg::uep_sel_e wr_sel;
	uep_pkg::uep_sel_e rd_sel;
	logic              cnt_clear;
	logic              cnt_load;
	logic              cnt_dec;
	logic              cnt_fire;

	// ----------------------------------------------------------------
	// Register address decode
	// ----------------------------------------------------------------
	function automatic uep_pkg::uep_sel_e msr_decode(input logic [31:0] addr);
		case (addr)
			uep_pkg::UEP_CFG_ADDR:    msr_decode = uep_pkg::UEP_SEL_CFG;
			uep_pkg::UEP_CBADDR_ADDR: msr_decode = uep_pkg::UEP_SEL_CB;
			default:                  msr_decode = uep_pkg::UEP_SEL_NONE;
		endcase
	endfunction

	assign prof_sup    = ext_feature_id_in[uep_pkg::UEP_ID_PROF_BIT];
	assign prof_avail  = prof_sup && extended_state_enable_mask_in[uep_pkg::UEP_XSTATE_BIT];
	assign wr_sel      = msr_wr_in ? msr_decode(msr_addr_in) : uep_pkg::UEP_SEL_NONE;
	assign rd_sel      = msr_rd_in ? msr_decode(msr_addr_in) : uep_pkg::UEP_SEL_NONE;
	// Reserved bits are never allowed; feature bits follow reported support
	assign cfg_allowed = uep_pkg::UEP_CFG_FIXED_MASK
		| (uep_pkg::UEP_CFG_FEAT_MASK & {32'h0, feature_support_in});

	assign cnt_clear = (wr_sel == uep_pkg::UEP_SEL_CB) && prof_sup && (msr_wdata_in == '0);
	assign cnt_load  = instr_valid_in && prof_avail
		&& (instr_op_in == uep_pkg::UEP_OP_LOAD) && (instr_addr_in != '0);
	assign cnt_dec   = instr_valid_in && prof_avail
		&& (instr_op_in == uep_pkg::UEP_OP_VALUE)
		&& (st_reg.mode == uep_pkg::UEP_MODE_ON) && st_reg.evt_sel[0];

	uep_sample_counter u_sample_counter (
		.clk_sys_in       (clk_sys_in),
		.rst_n_in         (rst_n_in),
		.clear_in         (cnt_clear),
		.load_in          (cnt_load),
		.load_count_in    (instr_count_in),
		.load_interval_in (instr_interval_in),
		.dec_in           (cnt_dec),
		.fire_out         (cnt_fire)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		st_next.ack       = 1'b0;
		st_next.gp        = 1'b0;
		st_next.done      = 1'b0;
		st_next.ud        = 1'b0;
		st_next.rec_valid = 1'b0;
		// Instructions
		if (instr_valid_in) begin
			st_next.done = 1'b1;
			if (!prof_avail) begin
				st_next.ud = 1'b1;
			end else begin
				case (instr_op_in)
					uep_pkg::UEP_OP_LOAD: begin
						// Address is taken as linear; no segment base applied
						st_next.cbaddr = instr_addr_in;
						if (instr_addr_in == '0) begin
							st_next.mode    = uep_pkg::UEP_MODE_OFF;
							st_next.evt_sel = '0;
						end else begin
							st_next.mode    = uep_pkg::UEP_MODE_ON;
							st_next.evt_sel = instr_flags_in
								& st_reg.cfg[uep_pkg::UEP_PERMIT_HI:uep_pkg::UEP_PERMIT_LO];
						end
					end
					uep_pkg::UEP_OP_STORE: begin
						st_next.result = (st_reg.mode == uep_pkg::UEP_MODE_ON)
							? st_reg.cbaddr : '0;
					end
					uep_pkg::UEP_OP_INSERT: begin
						if (st_reg.mode == uep_pkg::UEP_MODE_ON) begin
							st_next.rec_valid = 1'b1;
							st_next.rec_id    = uep_pkg::UEP_EVT_INSERT;
						end
					end
					uep_pkg::UEP_OP_VALUE: begin
						if (cnt_fire) begin
							st_next.rec_valid = 1'b1;
							st_next.rec_id    = uep_pkg::UEP_EVT_VALUE;
						end
					end
					default: begin
						st_next.ud = 1'b1;
					end
				endcase
			end
			st_next.rec_core = st_reg.cfg[uep_pkg::UEP_CORE_HI:uep_pkg::UEP_CORE_LO];
			st_next.rec_ts   = st_reg.cfg[uep_pkg::UEP_TIMESTAMP_STORE_ENABLE_BIT] && timestamp_present_in;
		end
		// State restore may install any address
		if (restore_valid_in) begin
			st_next.cbaddr  = restore_addr_in;
			st_next.mode    = (restore_addr_in != '0) ? uep_pkg::UEP_MODE_ON : uep_pkg::UEP_MODE_OFF;
			st_next.evt_sel = st_reg.cfg[uep_pkg::UEP_PERMIT_HI:uep_pkg::UEP_PERMIT_LO];
		end
		// Register reads
		if (rd_sel != uep_pkg::UEP_SEL_NONE) begin
			st_next.ack = 1'b1;
			if (!prof_sup) begin
				st_next.gp    = 1'b1;
				st_next.rdata = '0;
			end else if (rd_sel == uep_pkg::UEP_SEL_CFG) begin
				st_next.rdata = st_reg.cfg;
			end else begin
				st_next.rdata = st_reg.cbaddr;
			end
		end
		// Register writes, after instructions and restore so a stop wins over all but reset
		if (wr_sel != uep_pkg::UEP_SEL_NONE) begin
			st_next.ack = 1'b1;
			if (!prof_sup) begin
				st_next.gp = 1'b1;
			end else if (wr_sel == uep_pkg::UEP_SEL_CFG) begin
				if ((msr_wdata_in & ~cfg_allowed) != '0) begin
					st_next.gp = 1'b1;
				end else begin
					st_next.cfg = msr_wdata_in;
				end
			end else if (msr_wdata_in != '0) begin
				st_next.gp = 1'b1;
			end else begin
				st_next.cbaddr    = '0;
				st_next.mode      = uep_pkg::UEP_MODE_OFF;
				st_next.evt_sel   = '0;
				st_next.rec_valid = 1'b0;
			end
		end
		if (!rst_n_in) begin
			st_next        = '0;
			st_next.cfg    = uep_pkg::UEP_CFG_RESET;
			st_next.cbaddr = uep_pkg::UEP_CBADDR_RESET;
			st_next.mode   = uep_pkg::UEP_MODE_OFF;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign msr_ack_out                = st_reg.ack;
	assign msr_gp_fault_out           = st_reg.gp;
	assign msr_rdata_out              = st_reg.rdata;
	assign instr_done_out             = st_reg.done;
	assign instr_ud_fault_out         = st_reg.ud;
	assign instr_result_out           = st_reg.result;
	assign record_valid_out           = st_reg.rec_valid;
	assign record_event_id_out        = st_reg.rec_id;
	assign record_core_id_out         = st_reg.rec_core;
	assign record_timestamp_out       = st_reg.rec_ts;
	assign id_leaf_out                = {st_reg.cfg[uep_pkg::UEP_LEAF_HI:uep_pkg::UEP_LEAF_LO],
		1'b0};
	assign event_permit_out           = st_reg.evt_sel;
	assign continuous_mode_out        = st_reg.cfg[uep_pkg::UEP_CONT_BIT];
	assign timestamp_store_enable_out = st_reg.cfg[uep_pkg::UEP_TIMESTAMP_STORE_ENABLE_BIT];
	assign threshold_int_permit_out   = st_reg.cfg[uep_pkg::UEP_INT_BIT];
	assign int_vector_out             = st_reg.cfg[uep_pkg::UEP_VEC_HI:uep_pkg::UEP_VEC_LO];
	assign core_identifier_out        = st_reg.cfg[uep_pkg::UEP_CORE_HI:uep_pkg::UEP_CORE_LO];
	assign profiling_enabled_out      = (st_reg.mode == uep_pkg::UEP_MODE_ON);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb_sys @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	AST_NO_SUPPORT_GP: assert property (
		(msr_wr_in || msr_rd_in) && (msr_decode(msr_addr_in) != uep_pkg::UEP_SEL_NONE)
		&& !prof_sup |=> msr_gp_fault_out && msr_ack_out)
		else $error("access without profiling support did not fault");

	AST_CFG_BAD_GP: assert property (
		msr_wr_in && !msr_rd_in && !restore_valid_in && prof_sup
		&& (msr_addr_in == uep_pkg::UEP_CFG_ADDR) && ((msr_wdata_in & ~cfg_allowed) != '0)
		|=> msr_gp_fault_out && $stable(st_reg.cfg))
		else $error("unsupported configuration bit accepted");

	AST_LEAF_MIRROR: assert property (
		id_leaf_out[31:1] == st_reg.cfg[31:1] && id_leaf_out[0] == 1'b0)
		else $error("identification mirror differs from configuration");

	AST_RECORD_CORE_IDENTIFIER: assert property (
		instr_valid_in |=> record_core_id_out == $past(st_reg.cfg[39:32]))
		else $error("record core identifier not copied");

	AST_VECTOR: assert property (
		msr_wr_in && prof_sup && (msr_addr_in == uep_pkg::UEP_CFG_ADDR)
		&& ((msr_wdata_in & ~cfg_allowed) == '0)
		|=> int_vector_out == $past(msr_wdata_in[47:40]))
		else $error("interrupt vector not taken from bits 47:40");

	AST_CB_READ: assert property (
		msr_rd_in && !msr_wr_in && prof_sup && (msr_addr_in == uep_pkg::UEP_CBADDR_ADDR)
		|=> msr_ack_out && !msr_gp_fault_out && (msr_rdata_out == $past(st_reg.cbaddr)))
		else $error("address read wrong");

	AST_CB_NONZERO_GP: assert property (
		msr_wr_in && prof_sup && (msr_addr_in == uep_pkg::UEP_CBADDR_ADDR)
		&& (msr_wdata_in != '0) && !instr_valid_in && !restore_valid_in
		|=> msr_gp_fault_out ##0 $stable(st_reg.cbaddr))
		else $error("non-zero address write did not fault");

	AST_CB_ZERO_STOP: assert property (
		msr_wr_in && prof_sup && (msr_addr_in == uep_pkg::UEP_CBADDR_ADDR)
		&& (msr_wdata_in == '0)
		|=> !profiling_enabled_out && (st_reg.cbaddr == '0) && !record_valid_out)
		else $error("zero address write did not stop profiling");

	AST_UD: assert property (
		instr_valid_in && !prof_avail |=> instr_ud_fault_out && !record_valid_out)
		else $error("instruction without availability did not fault");

	AST_INSERT_RECORD: assert property (
		instr_valid_in && prof_avail && (instr_op_in == uep_pkg::UEP_OP_INSERT)
		&& profiling_enabled_out && !(msr_wr_in && msr_addr_in == uep_pkg::UEP_CBADDR_ADDR)
		|=> record_valid_out && (record_event_id_out == uep_pkg::UEP_EVT_INSERT))
		else $error("insert did not store a record");

	COV_LOAD_ON: cover property (
		instr_valid_in && prof_avail && (instr_op_in == uep_pkg::UEP_OP_LOAD)
		##1 profiling_enabled_out);
	COV_VALUE_FIRE: cover property (record_valid_out
		&& (record_event_id_out == uep_pkg::UEP_EVT_VALUE));
	COV_ZERO_STOP: cover property (profiling_enabled_out ##1 !profiling_enabled_out);
	COV_CFG_GP: cover property (msr_gp_fault_out && !instr_ud_fault_out);

endmodule // uep_profiling_regs

// ### rtl/uep_pkg.sv
// Constants and types shared by the user event profiling register block
package uep_pkg;

	// ----------------------------------------------------------------
	// Register addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] UEP_CFG_ADDR    = 32'hc000_0105;
	localparam logic [31:0] UEP_CBADDR_ADDR = 32'hc000_0106;
	localparam logic [63:0] UEP_CFG_RESET    = 64'h0;
	localparam logic [63:0] UEP_CBADDR_RESET = 64'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UEP_ID_PROF_BIT   = 15;
	localparam int UEP_XSTATE_BIT    = 62;
	localparam int UEP_PERMIT_LO     = 1;
	localparam int UEP_PERMIT_HI     = 6;
	localparam int UEP_CONT_BIT      = 29;
	localparam int UEP_TIMESTAMP_STORE_ENABLE_BIT      = 30;
	localparam int UEP_INT_BIT       = 31;
	localparam int UEP_CORE_LO       = 32;
	localparam int UEP_CORE_HI       = 39;
	localparam int UEP_VEC_LO        = 40;
	localparam int UEP_VEC_HI        = 47;
	localparam int UEP_LEAF_LO       = 1;
	localparam int UEP_LEAF_HI       = 31;

	// Bits always writable, and bits writable only when reported supported
	localparam logic [63:0] UEP_CFG_FIXED_MASK = 64'h0000_ffff_0000_0000;
	localparam logic [63:0] UEP_CFG_FEAT_MASK  = 64'h0000_0000_e000_007e;

	// ----------------------------------------------------------------
	// Event identifiers and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] UEP_EVT_VALUE  = 8'h01;
	localparam logic [7:0] UEP_EVT_INSERT = 8'hff;
	localparam int         UEP_CNT_W      = 32;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UEP_OP_LOAD   = 2'h0,
		UEP_OP_STORE  = 2'h1,
		UEP_OP_INSERT = 2'h2,
		UEP_OP_VALUE  = 2'h3
	} uep_op_e;

	typedef enum logic [1:0] {
		UEP_MODE_OFF = 2'b01,
		UEP_MODE_ON  = 2'b10
	} uep_mode_e;

	typedef enum logic [1:0] {
		UEP_SEL_NONE = 2'h0,
		UEP_SEL_CFG  = 2'h1,
		UEP_SEL_CB   = 2'h2
	} uep_sel_e;

endpackage

// ### rtl/uep_sample_counter.sv
// Event counter for the value-sample instruction
`timescale 1ns/10ps
module uep_sample_counter (
	input  wire logic                       clk_sys_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       clear_in,
	input  wire logic                       load_in,
	input  wire logic [uep_pkg::UEP_CNT_W-1:0] load_count_in,
	input  wire logic [uep_pkg::UEP_CNT_W-1:0] load_interval_in,
	input  wire logic                       dec_in,
	output logic                            fire_out
);

	typedef struct packed {
		logic [uep_pkg::UEP_CNT_W-1:0] count;
		logic [uep_pkg::UEP_CNT_W-1:0] interval;
	} uep_cnt_s;

	uep_cnt_s                      st_reg;
	uep_cnt_s                      st_next;
	logic [uep_pkg::UEP_CNT_W-1:0] dec_val;

	// ----------------------------------------------------------------
	// Decrement; a negative result fires and reloads the interval
	// ----------------------------------------------------------------
	always_comb begin
		st_next  = st_reg;
		dec_val  = st_reg.count - 1'b1;
		fire_out = dec_in && dec_val[uep_pkg::UEP_CNT_W-1];
		if (!rst_n_in || clear_in) begin
			st_next = '0;
		end else if (load_in) begin
			st_next.count    = load_count_in;
			st_next.interval = load_interval_in;
		end else if (dec_in) begin
			st_next.count = fire_out ? st_reg.interval : dec_val;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		st_reg <= st_next;
	end

endmodule // uep_sample_counter

// ### test/test_profiling_control_registers.sv
// Self-checking bench for the profiling configuration and control-block registers
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin fails++; \
	$display("FAIL %s expected %h seen %h", nm, ex, gt); end end

module test_profiling_control_registers;
	// ----------------------------------------------------------------
	// Design signals
	// ----------------------------------------------------------------
	logic        clk_sys_in, rst_n_in, timestamp_present_in, msr_rd_in, msr_wr_in;
	logic        instr_valid_in, restore_valid_in;
	logic [31:0] ext_feature_id_in, feature_support_in, msr_addr_in;
	logic [31:0] instr_count_in, instr_interval_in, id_leaf_out;
	logic [63:0] extended_state_enable_mask_in, msr_wdata_in, instr_addr_in, restore_addr_in;
	logic [63:0] msr_rdata_out, instr_result_out;
	logic [1:0]  instr_op_in;
	logic [5:0]  instr_flags_in, event_permit_out;
	logic        msr_ack_out, msr_gp_fault_out, instr_done_out, instr_ud_fault_out;
	logic        record_valid_out, record_timestamp_out, continuous_mode_out;
	logic        timestamp_store_enable_out, threshold_int_permit_out, profiling_enabled_out;
	logic [7:0]  record_event_id_out, record_core_id_out, int_vector_out, core_identifier_out;
	// Bench model state
	logic [63:0] m_cfg, m_cb, d, ok;
	logic        m_en;
	logic [5:0]  m_perm;
	integer      m_cnt, m_ivl, fails, tests_run, cycles, seed, i;

	uep_profiling_regs i_uep_profiling_regs (
		.clk_sys_in, .rst_n_in, .ext_feature_id_in, .feature_support_in,
		.extended_state_enable_mask_in, .timestamp_present_in, .msr_rd_in, .msr_wr_in,
		.msr_addr_in, .msr_wdata_in, .instr_valid_in, .instr_op_in, .instr_addr_in,
		.instr_flags_in, .instr_count_in, .instr_interval_in, .restore_valid_in,
		.restore_addr_in, .msr_ack_out, .msr_gp_fault_out, .msr_rdata_out, .instr_done_out,
		.instr_ud_fault_out, .instr_result_out, .record_valid_out, .record_event_id_out,
		.record_core_id_out, .record_timestamp_out, .id_leaf_out, .event_permit_out,
		.continuous_mode_out, .timestamp_store_enable_out, .threshold_int_permit_out,
		.int_vector_out, .core_identifier_out, .profiling_enabled_out);

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles > 20000) begin
			fails++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic msr(input logic wr, input logic [31:0] a, input logic [63:0] v);
		@(posedge clk_sys_in);
		#1;
		msr_wr_in = wr;
		msr_rd_in = ~wr;
		msr_addr_in = a;
		msr_wdata_in = v;
		@(posedge clk_sys_in);
		#1;
		msr_wr_in = 1'b0;
		msr_rd_in = 1'b0;
	endtask

	task automatic wr_cfg(input logic [63:0] v);
		logic g;
		ok = uep_pkg::UEP_CFG_FIXED_MASK | (uep_pkg::UEP_CFG_FEAT_MASK & {32'h0, feature_support_in});
		g = |(v & ~ok);
		msr(1'b1, uep_pkg::UEP_CFG_ADDR, v);
		`CHK("cfg_ack", 1'b1, msr_ack_out)
		`CHK("cfg_gp", g, msr_gp_fault_out)
		if (!g) m_cfg = v;
		msr(1'b0, uep_pkg::UEP_CFG_ADDR, 64'h0);
		`CHK("cfg_rd", m_cfg, msr_rdata_out)
		`CHK("leaf", {m_cfg[31:1], 1'b0}, id_leaf_out)
		`CHK("core", m_cfg[39:32], core_identifier_out)
		`CHK("vector", m_cfg[47:40], int_vector_out)
		`CHK("cont", m_cfg[29], continuous_mode_out)
		`CHK("tsen", m_cfg[30], timestamp_store_enable_out)
		`CHK("intp", m_cfg[31], threshold_int_permit_out)
	endtask

	task automatic ins(input logic [1:0] op, input logic [63:0] a, input logic [5:0] f,
			input logic [31:0] c);
		logic ud, rec;
		logic [7:0] id;
		ud = ~ext_feature_id_in[15] | ~extended_state_enable_mask_in[62];
		rec = 1'b0;
		id = uep_pkg::UEP_EVT_INSERT;
		@(posedge clk_sys_in);
		#1;
		instr_valid_in = 1'b1;
		instr_op_in = op;
		instr_addr_in = a;
		instr_flags_in = f;
		instr_count_in = c;
		instr_interval_in = m_ivl;
		@(posedge clk_sys_in);
		#1;
		instr_valid_in = 1'b0;
		`CHK("done", 1'b1, instr_done_out)
		`CHK("ud", ud, instr_ud_fault_out)
		if (!ud) begin
			case (op)
				2'h0: begin
					m_cb = a;
					m_en = (a != 64'h0);
					m_perm = f & m_cfg[6:1];
					m_cnt = $signed(c);
				end
				2'h1: `CHK("store", m_en ? m_cb : 64'h0, instr_result_out)
				2'h2: rec = m_en;
				default: begin
					id = uep_pkg::UEP_EVT_VALUE;
					if (m_en && m_perm[0]) begin
						m_cnt = m_cnt - 1;
						if (m_cnt < 0) begin
							rec = 1'b1;
							m_cnt = m_ivl;
						end
					end
				end
			endcase
		end
		`CHK("rec", rec, record_valid_out)
		if (rec) begin
			`CHK("rec_id", id, record_event_id_out)
			`CHK("rec_core", m_cfg[39:32], record_core_id_out)
			`CHK("rec_ts", m_cfg[30] & timestamp_present_in, record_timestamp_out)
		end
		`CHK("enabled", m_en, profiling_enabled_out)
		if (m_en) `CHK("permit", m_perm, event_permit_out)
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n_in, timestamp_present_in, msr_rd_in, msr_wr_in, instr_valid_in} = 5'h0;
		{restore_valid_in, msr_addr_in, instr_count_in, instr_interval_in} = 97'h0;
		{msr_wdata_in, instr_addr_in, restore_addr_in, instr_op_in, instr_flags_in} = 200'h0;
		ext_feature_id_in = 32'h0;
		feature_support_in = 32'hffff_ffff;
		extended_state_enable_mask_in = 64'h4000_0000_0000_0000;
		{fails, tests_run, cycles, m_cnt, m_ivl} = 0;
		seed = 42;
		{m_cfg, m_cb, m_en, m_perm} = 0;
		repeat (16) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		// No profiling support reported: accesses fault
		msr(1'b0, uep_pkg::UEP_CFG_ADDR, 64'h0);
		`CHK("nosup_gp", 1'b1, msr_gp_fault_out)
		`CHK("nosup_rd", 64'h0, msr_rdata_out)
		ins(2'h1, 64'h0, 6'h0, 32'h0);
		ext_feature_id_in = 32'h0000_8000;
		msr(1'b0, uep_pkg::UEP_CBADDR_ADDR, 64'h0);
		`CHK("cb_reset", uep_pkg::UEP_CBADDR_RESET, msr_rdata_out)
		`CHK("off_reset", 1'b0, profiling_enabled_out)
		msr(1'b0, 32'hc000_0107, 64'h0);
		`CHK("unmapped", 1'b0, msr_ack_out)
		// Random configuration writes against random support words
		for (i = 0; i < 24; i++) begin
			feature_support_in = $random(seed);
			d = {$random(seed), $random(seed)};
			if (i % 2) d = d & (uep_pkg::UEP_CFG_FIXED_MASK |
				(uep_pkg::UEP_CFG_FEAT_MASK & {32'h0, feature_support_in}));
			wr_cfg(d);
		end
		feature_support_in = 32'hffff_ffff;
		timestamp_present_in = 1'b1;
		// Software loads a small core identifier and a valid vector
		wr_cfg(64'h0000_a55a_e000_007e);
		// Address register rejects non-zero writes
		msr(1'b1, uep_pkg::UEP_CBADDR_ADDR, 64'h0000_0000_0001_1000);
		`CHK("cb_gp", 1'b1, msr_gp_fault_out)
		m_ivl = 1;
		ins(2'h0, 64'h0000_0000_0001_1000, 6'h3f, 32'h0);
		msr(1'b0, uep_pkg::UEP_CBADDR_ADDR, 64'h0);
		`CHK("cb_rd", m_cb, msr_rdata_out)
		ins(2'h1, 64'h0, 6'h0, 32'h0);
		ins(2'h2, 64'h0, 6'h0, 32'h0);
		repeat (3) ins(2'h3, 64'h0, 6'h0, 32'h0);
		timestamp_present_in = 1'b0;
		ins(2'h2, 64'h0, 6'h0, 32'h0);
		extended_state_enable_mask_in = 64'h0;
		ins(2'h2, 64'h0, 6'h0, 32'h0);
		extended_state_enable_mask_in = 64'h4000_0000_0000_0000;
		// Zero write stops profiling at once
		msr(1'b1, uep_pkg::UEP_CBADDR_ADDR, 64'h0);
		`CHK("cb0_gp", 1'b0, msr_gp_fault_out)
		`CHK("cb0_off", 1'b0, profiling_enabled_out)
		{m_cb, m_en, m_cnt, m_ivl} = 0;
		ins(2'h1, 64'h0, 6'h0, 32'h0);
		// State restore installs an address
		@(posedge clk_sys_in);
		#1;
		restore_valid_in = 1'b1;
		restore_addr_in = 64'h0000_0000_0000_2000;
		@(posedge clk_sys_in);
		#1;
		restore_valid_in = 1'b0;
		{m_cb, m_en, m_perm} = {64'h2000, 1'b1, m_cfg[6:1]};
		msr(1'b0, uep_pkg::UEP_CBADDR_ADDR, 64'h0);
		`CHK("restore_cb", m_cb, msr_rdata_out)
		repeat (2) ins(2'h3, 64'h0, 6'h0, 32'h0);
		// Mid-run reset while profiling is on clears both registers
		@(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		{m_cfg, m_cb, m_en, m_perm, m_cnt, m_ivl} = 0;
		`CHK("rst_off", 1'b0, profiling_enabled_out)
		`CHK("rst_core", 8'h0, core_identifier_out)
		msr(1'b0, uep_pkg::UEP_CFG_ADDR, 64'h0);
		`CHK("rst_cfg", uep_pkg::UEP_CFG_RESET, msr_rdata_out)
		msr(1'b0, uep_pkg::UEP_CBADDR_ADDR, 64'h0);
		`CHK("rst_cb", uep_pkg::UEP_CBADDR_RESET, msr_rdata_out)
		ins(2'h0, 64'h0, 6'h0, 32'h0);
		ins(2'h2, 64'h0, 6'h0, 32'h0);
		finish_test();
	end
endmodule // test_profiling_control_registers
